// ===== hdl/bus_map.svh
// Purpose: constants shared by both ends of the handshake bus link
// Assumes: levels are true-high inside the design; pads invert elsewhere
// Notes: addresses and the vector are board choices
//
// Notes on behaviour
// - 18 address, 16 data lines, no bus clock
// - cycle code: 00 read, 10 write, 11 byte
// - device ignores parity lines entirely
// - device answers only its own addresses
// - master sync after address; slave answers sync
// - slave read: data, then sync, drop both
// - write: data with sync, slave latches, unwinds
// - reads fetch, writes store, both directions
// - device raises dma request, awaits grant
// - processor grants only between cycles, then waits
// - dma grant passed on unless requesting
// - on grant: selection ack, drop request
// - wait busy low, take busy, transfer words
// - release busy after last word
// - interrupt request on completion when enabled
// - processor grants level only if accepting
// - interrupt grant passed on unless requesting
// - on interrupt grant: drop request, ack
// - take busy, vector strobe, drive vector
// - slave sync ends; drop busy, strobe, vector
// - bus clear returns device to cleared state
`ifndef BUS_MAP_SVH
`define BUS_MAP_SVH
`define CYC_READ        2'h0
`define CYC_WRITE       2'h2
`define CYC_BYTE        2'h3
`define DEV_BASE        18'h3F550
`define REG_STATUS_OFS  18'h00000
`define REG_CMD_OFS     18'h00002
`define REG_SPAN        18'h00004
`define INT_VECTOR      16'h0094
`define INT_LINE        1
`define CMD_RESET       16'h0000
`define MEM_WORDS       256
`endif

// ===== hdl/bus_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing beyond the constants header
// Notes: widths are fixed by the bus
package bus_pkg;
	typedef logic [17:0] addr_type;
	typedef logic [15:0] word_type;
	typedef logic [1:0]  cyc_type;
	typedef logic [3:0]  lines_type;
endpackage : bus_pkg

// ===== hdl/bus_link_if.sv
// Purpose: the shared bus between device end and processor end
// Assumes: each end raises an enable while it drives a shared line
// Notes: shared lines resolve here; device wins on a clash
interface bus_link_if;
	import bus_pkg::*;
	// shared lines, per-end value and enable
	addr_type  dev_addr_o, host_addr_o, addr;
	logic      dev_addr_oe, host_addr_oe;
	word_type  dev_data_o, host_data_o, data;
	logic      dev_data_oe, host_data_oe;
	cyc_type   dev_cyc_o, host_cyc_o, cyc;
	logic      dev_cyc_oe, host_cyc_oe;
	// open-drain control lines, enable means asserted
	logic      dev_msync_oe, host_msync_oe, msync;
	logic      dev_ssync_oe, host_ssync_oe, ssync;
	logic      dev_bus_busy_flag_oe, host_bus_busy_flag_oe, bus_busy_flag;
	// lines with one driver each
	logic      dma_request, selection_ack, vector_strobe, dma_grant, npg_out, init;
	lines_type br, bg, bg_out;

	assign addr  = dev_addr_oe ? dev_addr_o : (host_addr_oe ? host_addr_o : '0);
	assign data  = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : '0);
	assign cyc   = dev_cyc_oe ? dev_cyc_o : (host_cyc_oe ? host_cyc_o : '0);
	assign msync = dev_msync_oe | host_msync_oe;
	assign ssync = dev_ssync_oe | host_ssync_oe;
	assign bus_busy_flag  = dev_bus_busy_flag_oe | host_bus_busy_flag_oe;

	modport dev_end (
		input  addr, data, cyc, msync, ssync, bus_busy_flag, dma_grant, bg, init,
		output dev_addr_o, dev_addr_oe, dev_data_o, dev_data_oe,
		output dev_cyc_o, dev_cyc_oe, dev_msync_oe, dev_ssync_oe,
		output dev_bus_busy_flag_oe, dma_request, selection_ack, vector_strobe, br, npg_out, bg_out
	);
	modport host_end (
		input  addr, data, cyc, msync, ssync, bus_busy_flag, dma_request, selection_ack, vector_strobe, br,
		output host_addr_o, host_addr_oe, host_data_o, host_data_oe,
		output host_cyc_o, host_cyc_oe, host_msync_oe, host_ssync_oe,
		output host_bus_busy_flag_oe, dma_grant, bg, init
	);
endinterface : bus_link_if

// ===== hdl/bus_device_end.sv
// Purpose: tape controller bus end: register slave, dma master, interrupter
// Assumes: bus lines synchronous to core_clk; tape logic on user ports
// Notes: one master sequence at a time; dma has priority over interrupt
`include "bus_map.svh"
module bus_device_end (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	// bus
	bus_link_if.dev_end             bus,
	// register face
	input  wire bus_pkg::word_type  status_word,
	output logic                    cmd_strobe,
	output bus_pkg::word_type       cmd_word,
	output logic [1:0]              cmd_be,
	// memory transfer stream
	input  wire logic               xfer_valid,
	output logic                    xfer_ready,
	input  wire logic               xfer_to_mem,
	input  wire logic               xfer_last,
	input  wire bus_pkg::addr_type  xfer_addr,
	input  wire bus_pkg::word_type  xfer_wdata,
	output logic                    rd_valid,
	output bus_pkg::word_type       rd_data,
	// completion interrupt
	input  wire logic               int_enable,
	input  wire logic               op_done
);
	import bus_pkg::*;

	typedef enum {SLV_IDLE, SLV_DATA, SLV_ACK} slv_type;
	typedef enum {M_IDLE, M_REQ, M_SEL, M_ADR, M_SYN, M_FIN, M_LOAD,
		M_VEC, M_VEND} mst_type;

	slv_type  slv_reg;
	mst_type  mst_reg;
	logic     kind_int_reg;
	logic     int_pend_reg;
	logic     to_mem_reg;
	logic     last_reg;
	addr_type addr_reg;
	word_type wdata_reg;
	word_type rdback_reg;
	logic     slv_read_reg;
	logic     slv_hit;
	logic     req_dma;
	logic     req_int;

	// true when the address falls in this device's register window
	function automatic logic own_addr(input addr_type a);
		own_addr = (a >= `DEV_BASE) && (a < `DEV_BASE + `REG_SPAN);
	endfunction : own_addr

	// word offset within the window, byte bit dropped
	function automatic addr_type reg_ofs(input addr_type a);
		reg_ofs = (a - `DEV_BASE) & ~18'h00001;
	endfunction : reg_ofs

	////////////////////////////////////////////////////////////////////
	// slave side

	// only a true master cycle from someone else may select us
	assign slv_hit = bus.msync && !bus.dev_msync_oe && own_addr(bus.addr);

	// register slave: data first, sync next, release on master sync fall
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			slv_reg <= SLV_IDLE;
			slv_read_reg <= 1'b0;
			rdback_reg <= '0;
		end
		else if (bus.init)
		begin
			slv_reg <= SLV_IDLE;
			slv_read_reg <= 1'b0;
		end
		else
		begin
			unique case (slv_reg)
				SLV_IDLE:
					if (slv_hit)
					begin
						slv_reg <= SLV_DATA;
						slv_read_reg <= (bus.cyc == `CYC_READ);
						rdback_reg <= (reg_ofs(bus.addr) == `REG_STATUS_OFS)
							? status_word : cmd_word;
					end
				SLV_DATA:
					slv_reg <= SLV_ACK;
				SLV_ACK:
					if (!bus.msync)
						slv_reg <= SLV_IDLE;
			endcase
		end
	end

	// command capture happens while data is still held with sync
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_word <= `CMD_RESET;
			cmd_be <= 2'h0;
			cmd_strobe <= 1'b0;
		end
		else if (bus.init)
		begin
			cmd_word <= `CMD_RESET;
			cmd_be <= 2'h0;
			cmd_strobe <= 1'b0;
		end
		else
		begin
			cmd_strobe <= 1'b0;
			if (slv_reg == SLV_IDLE && slv_hit && bus.cyc[1]
				&& reg_ofs(bus.addr) == `REG_CMD_OFS)
			begin
				cmd_strobe <= 1'b1;
				if (bus.cyc == `CYC_BYTE)
				begin
					cmd_be <= bus.addr[0] ? 2'h2 : 2'h1;
					if (bus.addr[0])
						cmd_word[15:8] <= bus.data[15:8];
					else
						cmd_word[7:0] <= bus.data[7:0];
				end
				else
				begin
					cmd_be <= 2'h3;
					cmd_word <= bus.data;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// completion interrupt

	// a completion in the capture cycle survives: set wins over clear
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			int_pend_reg <= 1'b0;
		else if (bus.init)
			int_pend_reg <= 1'b0;
		else if (op_done && int_enable)
			int_pend_reg <= 1'b1;
		else if (mst_reg == M_REQ && kind_int_reg && bus.bg[`INT_LINE])
			int_pend_reg <= 1'b0;
		else if (!int_enable)
			int_pend_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// bus master sequencer

	assign xfer_ready = (mst_reg == M_IDLE) || (mst_reg == M_LOAD);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mst_reg <= M_IDLE;
			kind_int_reg <= 1'b0;
			to_mem_reg <= 1'b0;
			last_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
		end
		else if (bus.init)
		begin
			mst_reg <= M_IDLE;
			kind_int_reg <= 1'b0;
		end
		else
		begin
			unique case (mst_reg)
				M_IDLE:
					if (xfer_valid)
					begin
						mst_reg <= M_REQ;
						kind_int_reg <= 1'b0;
						to_mem_reg <= xfer_to_mem;
						last_reg <= xfer_last;
						addr_reg <= xfer_addr;
						wdata_reg <= xfer_wdata;
					end
					else if (int_pend_reg)
					begin
						mst_reg <= M_REQ;
						kind_int_reg <= 1'b1;
					end
				M_REQ:
					if (kind_int_reg ? bus.bg[`INT_LINE] : bus.dma_grant)
						mst_reg <= M_SEL;
				M_SEL:
					// grant must be gone too, else a stale grant looks new
					if (!bus.bus_busy_flag && !bus.dma_grant && !bus.bg[`INT_LINE])
						mst_reg <= kind_int_reg ? M_VEC : M_ADR;
				M_ADR:
					mst_reg <= M_SYN;
				M_SYN:
					if (bus.ssync)
						mst_reg <= M_FIN;
				M_FIN:
					if (!bus.ssync)
						mst_reg <= last_reg ? M_IDLE : M_LOAD;
				M_LOAD:
					// bus stays owned while the stream catches up
					if (xfer_valid)
					begin
						mst_reg <= M_ADR;
						to_mem_reg <= xfer_to_mem;
						last_reg <= xfer_last;
						addr_reg <= xfer_addr;
						wdata_reg <= xfer_wdata;
					end
				M_VEC:
					if (bus.ssync)
						mst_reg <= M_VEND;
				M_VEND:
					if (!bus.ssync)
						mst_reg <= M_IDLE;
			endcase
		end
	end

	// memory read data is taken as slave sync arrives
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else
		begin
			rd_valid <= 1'b0;
			if (mst_reg == M_SYN && bus.ssync && !to_mem_reg && !bus.init)
			begin
				rd_valid <= 1'b1;
				rd_data <= bus.data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// bus drive

	assign req_dma = (mst_reg == M_REQ || mst_reg == M_SEL) && !kind_int_reg;
	assign req_int = (mst_reg == M_REQ || mst_reg == M_SEL) && kind_int_reg;

	// request, acknowledge and grant chain
	always_comb
	begin
		bus.dma_request = (mst_reg == M_REQ) && !kind_int_reg;
		bus.br = '0;
		bus.br[`INT_LINE] = (mst_reg == M_REQ) && kind_int_reg;
		bus.selection_ack = (mst_reg == M_SEL);
		bus.npg_out = bus.dma_grant && !req_dma;
		bus.bg_out = bus.bg;
		bus.bg_out[`INT_LINE] = bus.bg[`INT_LINE] && !req_int;
	end

	// master lines; parity is neither driven nor looked at
	always_comb
	begin
		bus.dev_bus_busy_flag_oe = !(mst_reg inside {M_IDLE, M_REQ, M_SEL});
		bus.dev_addr_oe = (mst_reg == M_ADR) || (mst_reg == M_SYN);
		bus.dev_addr_o = addr_reg;
		bus.dev_cyc_oe = bus.dev_addr_oe;
		bus.dev_cyc_o = to_mem_reg ? `CYC_WRITE : `CYC_READ;
		bus.dev_msync_oe = (mst_reg == M_SYN);
		bus.vector_strobe = (mst_reg == M_VEC) || (mst_reg == M_VEND);
		bus.dev_ssync_oe = (slv_reg == SLV_ACK);
	end

	// data lines: vector, outgoing word, or register read-back
	always_comb
	begin
		bus.dev_data_oe = 1'b0;
		bus.dev_data_o = '0;
		if (bus.vector_strobe)
		begin
			bus.dev_data_oe = 1'b1;
			bus.dev_data_o = `INT_VECTOR;
		end
		else if (bus.dev_addr_oe && to_mem_reg)
		begin
			bus.dev_data_oe = 1'b1;
			bus.dev_data_o = wdata_reg;
		end
		else if (slv_reg != SLV_IDLE && slv_read_reg)
		begin
			bus.dev_data_oe = 1'b1;
			bus.dev_data_o = rdback_reg;
		end
	end
endmodule : bus_device_end

// ===== hdl/bus_host_end.sv
// Purpose: processor end: bus cycles, memory slave, grants, vector intake
// Assumes: commands and interrupt acceptance come from the user ports
// Notes: the memory is small; addresses past it are not answered
`include "bus_map.svh"
module bus_host_end (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	// bus
	bus_link_if.host_end            bus,
	// clear and interrupt acceptance
	input  wire logic               clear_req,
	input  wire bus_pkg::lines_type int_accept,
	output logic                    vec_valid,
	output bus_pkg::word_type       vec_data,
	// processor cycles
	input  wire logic               cmd_valid,
	output logic                    cmd_ready,
	input  wire bus_pkg::cyc_type   cmd_kind,
	input  wire bus_pkg::addr_type  cmd_addr,
	input  wire bus_pkg::word_type  cmd_wdata,
	output logic                    rsp_valid,
	output bus_pkg::word_type       rsp_data
);
	import bus_pkg::*;

	typedef enum {H_IDLE, H_ADR, H_SYN, H_FIN} hm_type;
	typedef enum {S_IDLE, S_DATA, S_ACK} hs_type;
	typedef enum {V_IDLE, V_ACK, V_WAIT} hv_type;

	hm_type    hm_reg;
	hs_type    hs_reg;
	hv_type    hv_reg;
	cyc_type   kind_reg;
	addr_type  addr_reg;
	word_type  wdata_reg;
	word_type  mrd_reg;
	logic      npg_reg;
	lines_type bg_reg;
	logic      quiet;
	logic      mem_hit;
	word_type  mem [`MEM_WORDS];

	// no cycle, no grant out, no foreign owner: a new cycle may start
	assign quiet = (hm_reg == H_IDLE) && !npg_reg && bg_reg == '0 && !bus.selection_ack
		&& !bus.bus_busy_flag;
	assign cmd_ready = quiet && !bus.dma_request && !clear_req;
	assign mem_hit = bus.msync && !bus.host_msync_oe && bus.addr < 18'(2 * `MEM_WORDS);

	// processor bus cycles
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			hm_reg <= H_IDLE;
			kind_reg <= `CYC_READ;
			addr_reg <= '0;
			wdata_reg <= '0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			unique case (hm_reg)
				H_IDLE:
					if (cmd_valid && cmd_ready)
					begin
						hm_reg <= H_ADR;
						kind_reg <= cmd_kind;
						addr_reg <= cmd_addr;
						wdata_reg <= cmd_wdata;
					end
				H_ADR:
					hm_reg <= H_SYN;
				H_SYN:
					if (bus.ssync)
					begin
						hm_reg <= H_FIN;
						rsp_data <= bus.data;
					end
				H_FIN:
					if (!bus.ssync)
					begin
						hm_reg <= H_IDLE;
						rsp_valid <= 1'b1;
					end
			endcase
		end
	end

	// grants go out only between cycles; withdrawn on selection ack
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			npg_reg <= 1'b0;
			bg_reg <= '0;
		end
		else if (bus.selection_ack || clear_req)
		begin
			npg_reg <= 1'b0;
			bg_reg <= '0;
		end
		else if (quiet && bus.dma_request)
			npg_reg <= 1'b1;
		else if (quiet)
		begin
			for (int i = 3; i >= 0; i--)
				if (bg_reg == '0 && bus.br[i] && int_accept[i])
					bg_reg[i] <= 1'b1;
		end
	end

	// memory as slave for the device's transfers
	always_ff @(posedge core_clk)
	begin
		if (hs_reg == S_IDLE && mem_hit && bus.cyc[1])
		begin
			if (bus.cyc != `CYC_BYTE || !bus.addr[0])
				mem[bus.addr[8:1]][7:0] <= bus.data[7:0];
			if (bus.cyc != `CYC_BYTE || bus.addr[0])
				mem[bus.addr[8:1]][15:8] <= bus.data[15:8];
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			hs_reg <= S_IDLE;
			mrd_reg <= '0;
		end
		else
		begin
			unique case (hs_reg)
				S_IDLE:
					if (mem_hit)
					begin
						hs_reg <= S_DATA;
						mrd_reg <= mem[bus.addr[8:1]];
					end
				S_DATA:
					hs_reg <= S_ACK;
				S_ACK:
					if (!bus.msync)
						hs_reg <= S_IDLE;
			endcase
		end
	end

	// vector intake: take it, pulse sync, wait for strobe to drop
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			hv_reg <= V_IDLE;
			vec_valid <= 1'b0;
			vec_data <= '0;
		end
		else
		begin
			vec_valid <= 1'b0;
			unique case (hv_reg)
				V_IDLE:
					if (bus.vector_strobe)
					begin
						hv_reg <= V_ACK;
						vec_valid <= 1'b1;
						vec_data <= bus.data;
					end
				V_ACK:
					hv_reg <= V_WAIT;
				V_WAIT:
					if (!bus.vector_strobe)
						hv_reg <= V_IDLE;
			endcase
		end
	end

	// bus drive
	always_comb
	begin
		bus.init = clear_req;
		bus.dma_grant = npg_reg;
		bus.bg = bg_reg;
		bus.host_bus_busy_flag_oe = (hm_reg != H_IDLE);
		bus.host_addr_oe = (hm_reg == H_ADR) || (hm_reg == H_SYN);
		bus.host_addr_o = addr_reg;
		bus.host_cyc_oe = bus.host_addr_oe;
		bus.host_cyc_o = kind_reg;
		bus.host_msync_oe = (hm_reg == H_SYN);
		bus.host_ssync_oe = (hs_reg == S_ACK) || (hv_reg == V_ACK);
		bus.host_data_oe = (bus.host_addr_oe && kind_reg[1])
			|| (hs_reg != S_IDLE && !bus.cyc[1]);
		bus.host_data_o = bus.host_addr_oe ? wdata_reg : mrd_reg;
	end
endmodule : bus_host_end

// ===== tb/bus_link_props.sv
// Purpose: concurrent checks on the shared bus between the two ends
// Assumes: all bus lines sampled on core_clk; rst is the only disable
// Notes: bus clear is not a disable, so checks tolerate it where they must
`include "bus_map.svh"
module bus_link_props (
	// clock and reset
	input wire logic               core_clk,
	input wire logic               rst,
	// shared lines
	input wire bus_pkg::addr_type  addr,
	input wire bus_pkg::word_type  data,
	input wire bus_pkg::cyc_type   cyc,
	input wire logic               msync,
	input wire logic               ssync,
	input wire logic               bus_busy_flag,
	// device enables
	input wire logic               dev_addr_oe,
	input wire logic               dev_data_oe,
	input wire logic               dev_cyc_oe,
	input wire logic               dev_msync_oe,
	input wire logic               dev_ssync_oe,
	input wire logic               dev_bus_busy_flag_oe,
	// arbitration
	input wire logic               dma_request,
	input wire logic               selection_ack,
	input wire logic               vector_strobe,
	input wire logic               dma_grant,
	input wire logic               npg_out,
	input wire logic               init,
	input wire bus_pkg::lines_type br,
	input wire bus_pkg::lines_type bg,
	input wire bus_pkg::lines_type bg_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import bus_pkg::*;
	logic in_win;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// window decode kept apart so the properties stay short
	assign in_win = (addr >= `DEV_BASE) && (addr < `DEV_BASE + `REG_SPAN);
	////////////////////////////////////////////////////////////////////////
	// multi-step tails
	sequence s_grab;
		##[1:2] (selection_ack && !dma_request);
	endsequence
	sequence s_vec_end;
		##[0:2] (!vector_strobe && !dev_bus_busy_flag_oe && !dev_data_oe);
	endsequence
	sequence s_int_grab;
		##[1:2] (!br[`INT_LINE] && selection_ack);
	endsequence
	////////////////////////////////////////////////////////////////////////
	// cyc reads as a read once the master lets go, so only judge while sync still stands
	a_read_data_first: assert property (dev_ssync_oe && msync && cyc == `CYC_READ |->
		dev_data_oe)
		else $error("slave sync on read without data");
	a_read_release: assert property (dev_ssync_oe && $fell(msync) |->
		##[1:2] (!dev_ssync_oe && !dev_data_oe))
		else $error("slave kept sync or data after master sync fell");
	a_own_addr: assert property ($rose(dev_ssync_oe) |-> in_win)
		else $error("device answered a foreign address");
	a_slave_answer: assert property (msync && in_win && !dev_bus_busy_flag_oe && !init |->
		##[1:3] dev_ssync_oe)
		else $error("device did not answer its own address");
	a_addr_first: assert property ($rose(dev_msync_oe) |-> $past(dev_addr_oe) && dev_addr_oe)
		else $error("master sync before address");
	a_cyc_code: assert property (dev_msync_oe |->
		dev_cyc_oe && (cyc == `CYC_READ || cyc == `CYC_WRITE))
		else $error("bad cycle code from device master");
	a_dma_grab: assert property (dma_request && dma_grant && !init |-> s_grab)
		else $error("grant not captured");
	a_dma_block: assert property (dma_grant && (dma_request || selection_ack) |-> !npg_out)
		else $error("dma grant passed on by requester");
	a_busy_wait: assert property ($rose(dev_bus_busy_flag_oe) |-> !$past(bus_busy_flag))
		else $error("busy taken while bus busy");
	a_ack_hold: assert property ($fell(selection_ack) && !init && !$past(init) |-> dev_bus_busy_flag_oe)
		else $error("selection ack dropped before busy taken");
	a_vec_drive: assert property ($rose(vector_strobe) |->
		dev_bus_busy_flag_oe && dev_data_oe && data == `INT_VECTOR)
		else $error("vector strobe without busy or vector");
	a_vec_end: assert property (vector_strobe && $fell(ssync) |-> s_vec_end)
		else $error("vector not removed after slave sync fell");
	a_int_grab: assert property (bg[`INT_LINE] && br[`INT_LINE] && !init |-> s_int_grab)
		else $error("interrupt grant not captured");
	a_int_block: assert property (bg[`INT_LINE] && br[`INT_LINE] |-> !bg_out[`INT_LINE])
		else $error("interrupt grant passed on by requester");
endmodule : bus_link_props

// ===== tb/async_bus_dma_interrupt_port_tb.sv
// Purpose: both bus ends joined; register, dma, interrupt and clear scenarios
// Assumes: host memory answers 0..0x1FF; only the device register window answers elsewhere
// Notes: inputs change by non-blocking assignment on the rising edge
`include "bus_map.svh"
module async_bus_dma_interrupt_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bus_pkg::*;
	logic      core_clk, rst, clear_req, cmd_valid, xfer_valid, xfer_to_mem, xfer_last;
	logic      int_enable, op_done, cmd_strobe, xfer_ready, rd_valid, vec_valid;
	logic      cmd_ready, rsp_valid;
	logic [1:0] cmd_be;
	lines_type int_accept;
	cyc_type   cmd_kind;
	addr_type  cmd_addr, xfer_addr;
	word_type  cmd_wdata, xfer_wdata, status_word, cmd_word, rd_data, vec_data, rsp_data, r;
	int        fail_count, check_count, strobe_count;
	bus_link_if bus_link_if_i();
	bus_device_end bus_device_end_i(.core_clk(core_clk), .rst(rst), .bus(bus_link_if_i),
		.status_word(status_word), .cmd_strobe(cmd_strobe), .cmd_word(cmd_word),
		.cmd_be(cmd_be), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
		.xfer_to_mem(xfer_to_mem), .xfer_last(xfer_last), .xfer_addr(xfer_addr),
		.xfer_wdata(xfer_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
		.int_enable(int_enable), .op_done(op_done));
	bus_host_end bus_host_end_i(.core_clk(core_clk), .rst(rst), .bus(bus_link_if_i),
		.clear_req(clear_req), .int_accept(int_accept), .vec_valid(vec_valid),
		.vec_data(vec_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	bus_link_props bus_link_props_i(.core_clk(core_clk), .rst(rst),
		.addr(bus_link_if_i.addr), .data(bus_link_if_i.data), .cyc(bus_link_if_i.cyc),
		.msync(bus_link_if_i.msync), .ssync(bus_link_if_i.ssync), .bus_busy_flag(bus_link_if_i.bus_busy_flag),
		.dev_addr_oe(bus_link_if_i.dev_addr_oe), .dev_data_oe(bus_link_if_i.dev_data_oe),
		.dev_cyc_oe(bus_link_if_i.dev_cyc_oe), .dev_msync_oe(bus_link_if_i.dev_msync_oe),
		.dev_ssync_oe(bus_link_if_i.dev_ssync_oe), .dev_bus_busy_flag_oe(bus_link_if_i.dev_bus_busy_flag_oe),
		.dma_request(bus_link_if_i.dma_request), .selection_ack(bus_link_if_i.selection_ack), .vector_strobe(bus_link_if_i.vector_strobe),
		.dma_grant(bus_link_if_i.dma_grant), .npg_out(bus_link_if_i.npg_out), .init(bus_link_if_i.init),
		.br(bus_link_if_i.br), .bg(bus_link_if_i.bg), .bg_out(bus_link_if_i.bg_out));
	// free-running 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// command strobes are one cycle wide, so count them rather than catch them
	always @(posedge core_clk)
		if (cmd_strobe === 1'b1)
			strobe_count <= strobe_count + 1;
	////////////////////////////////////////////////////////////////////////
	task results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	task check(input string name, input logic [17:0] seen, input logic [17:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// a wait that ran out ends the run at once, the bus is likely stuck
	task tmo(input string name);
		check(name, 18'h0, 18'h1);
		results();
	endtask : tmo
	// one processor cycle; request held until the taking edge
	task host_cyc(input cyc_type k, input addr_type a, input word_type w, output word_type d);
		int n;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_addr <= a;
		cmd_wdata <= w;
		n = 0;
		do @(negedge core_clk); while (cmd_ready !== 1'b1 && ++n < 200);
		if (n >= 200) tmo("cmd_ready");
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		n = 0;
		do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 200);
		if (n >= 200) tmo("rsp_valid");
		d = rsp_data;
	endtask : host_cyc
	// one device word to or from memory through dma
	task dev_xfer(input logic to_mem, input logic last, input addr_type a, input word_type w);
		int n;
		@(posedge core_clk);
		xfer_valid <= 1'b1;
		xfer_to_mem <= to_mem;
		xfer_last <= last;
		xfer_addr <= a;
		xfer_wdata <= w;
		n = 0;
		do @(negedge core_clk); while (xfer_ready !== 1'b1 && ++n < 200);
		if (n >= 200) tmo("xfer_ready");
		@(posedge core_clk);
		xfer_valid <= 1'b0;
		n = 0;
		if (!to_mem)
		begin
			do @(negedge core_clk); while (rd_valid !== 1'b1 && ++n < 200);
			if (n >= 200) tmo("rd_valid");
		end
	endtask : dev_xfer
	task pulse_done;
		@(posedge core_clk);
		op_done <= 1'b1;
		@(posedge core_clk);
		op_done <= 1'b0;
		repeat (4) @(negedge core_clk);
	endtask : pulse_done
	////////////////////////////////////////////////////////////////////////
	task t_regs;
		int v;
		host_cyc(`CYC_READ, `DEV_BASE + `REG_STATUS_OFS, 16'h0000, r);
		check("status", r, 16'hC3A5);
		host_cyc(`CYC_WRITE, `DEV_BASE + `REG_CMD_OFS, 16'h1234, r);
		check("cmd_word", cmd_word, 16'h1234);
		check("cmd_be", cmd_be, 2'h3);
		host_cyc(`CYC_BYTE, `DEV_BASE + `REG_CMD_OFS + 18'h1, 16'hABAB, r);
		check("cmd_byte", cmd_word, 16'hAB34);
		check("cmd_be_hi", cmd_be, 2'h2);
		check("cmd_strobe", strobe_count, 2);
		host_cyc(`CYC_READ, `DEV_BASE + `REG_CMD_OFS, 16'h0000, r);
		check("cmd_read", r, 16'hAB34);
		// foreign address: nothing answers, so only a reset ends the host cycle
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= `CYC_READ;
		cmd_addr <= 18'h00010;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		v = 0;
		repeat (20) @(negedge core_clk) v += bus_link_if_i.ssync;
		check("foreign", v, 0);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
	endtask : t_regs
	task t_dma;
		int n;
		// the host memory only serves the device, so dma reads back what dma wrote
		dev_xfer(1'b1, 1'b0, 18'h00020, 16'h9C31);
		dev_xfer(1'b1, 1'b0, 18'h00010, 16'h5A5A);
		dev_xfer(1'b0, 1'b0, 18'h00020, 16'h0000);
		check("dma_wr", rd_data, 16'h9C31);
		dev_xfer(1'b0, 1'b1, 18'h00010, 16'h0000);
		check("dma_rd", rd_data, 16'h5A5A);
		n = 0;
		do @(negedge core_clk); while (bus_link_if_i.bus_busy_flag !== 1'b0 && ++n < 200);
		if (n >= 200) tmo("bus_busy_flag");
		check("dma_busy", bus_link_if_i.dev_bus_busy_flag_oe, 1'b0);
	endtask : t_dma
	task t_int;
		int n;
		int v;
		@(posedge core_clk);
		int_enable <= 1'b1;
		pulse_done();
		v = 0;
		repeat (20) @(negedge core_clk) v += vec_valid;
		check("br_req", bus_link_if_i.br[`INT_LINE], 1'b1);
		check("no_vec", v, 0);
		@(posedge core_clk);
		int_accept <= 4'h2;
		n = 0;
		do @(negedge core_clk); while (vec_valid !== 1'b1 && ++n < 200);
		if (n >= 200) tmo("vec_valid");
		check("vector", vec_data, `INT_VECTOR);
		n = 0;
		do @(negedge core_clk); while (bus_link_if_i.vector_strobe !== 1'b0 && ++n < 20);
		if (n >= 20) tmo("vector_strobe");
		check("vector_strobe_off", bus_link_if_i.vector_strobe, 1'b0);
		check("br_off", bus_link_if_i.br[`INT_LINE], 1'b0);
		@(posedge core_clk);
		int_enable <= 1'b0;
		pulse_done();
		check("br_masked", bus_link_if_i.br[`INT_LINE], 1'b0);
		@(posedge core_clk);
		int_accept <= 4'h0;
	endtask : t_int
	task t_clear;
		host_cyc(`CYC_WRITE, `DEV_BASE + `REG_CMD_OFS, 16'h00FF, r);
		@(posedge core_clk);
		int_enable <= 1'b1;
		pulse_done();
		check("br_pend", bus_link_if_i.br[`INT_LINE], 1'b1);
		@(posedge core_clk);
		clear_req <= 1'b1;
		repeat (3) @(posedge core_clk);
		clear_req <= 1'b0;
		int_enable <= 1'b0;
		@(negedge core_clk);
		check("clr_cmd", cmd_word, `CMD_RESET);
		check("clr_br", bus_link_if_i.br[`INT_LINE], 1'b0);
	endtask : t_clear
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{clear_req, cmd_valid, xfer_valid, xfer_to_mem, xfer_last, int_enable, op_done} = '0;
		{int_accept, cmd_kind, cmd_addr, xfer_addr, cmd_wdata, xfer_wdata} = '0;
		status_word = 16'hC3A5;
		fail_count = 0;
		check_count = 0;
		strobe_count = 0;
		rst = 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_dma();
		t_int();
		t_clear();
		results();
	end
endmodule : async_bus_dma_interrupt_port_tb
